/* File: logic/mapper_ctrl_pkg.sv */
package mapper_ctrl_pkg;
	// =====================================================================
	// register indices (printed offsets are not multiples of four,
	// so each is an index and the byte address is four times it)
	localparam logic [7:0] IDX_OVH_PRBS   = 8'hC6;
	localparam logic [7:0] IDX_B3_PTR_RST = 8'hC7;
	localparam logic [7:0] IDX_EXP_LABEL  = 8'hC8;
	localparam logic [7:0] IDX_RDI_FEBE   = 8'hC9;
	localparam logic [7:0] IDX_B3_BYTE    = 8'h40;
	localparam logic [7:0] IDX_RX_C2      = 8'h91;
	localparam logic [7:0] IDX_FEBE_LO    = 8'hAA;
	localparam logic [7:0] IDX_FEBE_HI    = 8'hAB;
	localparam logic [7:0] IDX_PRBS_LO    = 8'hAE;
	localparam logic [7:0] IDX_PRBS_HI    = 8'hAF;
	localparam logic [7:0] IDX_STATUS     = 8'hB0;
	// =====================================================================
	// field positions
	localparam int BIT_FAST_PTR   = 7;
	localparam int BIT_TOH_GEN    = 6;
	localparam int BIT_H4_CNT     = 5;
	localparam int BIT_LONG_PAT   = 4;
	localparam int BIT_ANA_EN     = 3;
	localparam int BIT_ANA_SRC    = 2;
	localparam int BIT_TX_PAT     = 1;
	localparam int BIT_RX_PAT     = 0;
	localparam int BIT_B3_OVR     = 7;
	localparam int BIT_FIX_PTR    = 6;
	localparam int BIT_RSVD_ONE   = 5;
	localparam int BIT_PD_GAIN    = 4;
	localparam int BIT_LOOP_INV   = 3;
	localparam int BIT_TX_RST     = 2;
	localparam int BIT_RX_RST     = 1;
	localparam int BIT_CNT_CLR    = 0;
	localparam int BIT_RDI_PERS   = 1;
	localparam int BIT_FEBE_BLK   = 0;
	localparam int BIT_RDI_STATE  = 2;
	localparam int BIT_LABEL_ERR  = 1;
	// =====================================================================
	// reset values and constants
	localparam logic [7:0]  RST_OVH_PRBS   = 8'h00;
	localparam logic [7:0]  RST_B3_PTR_RST = 8'h20;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [15:0] TOH_POINTER    = 16'h6000;
	localparam logic [9:0]  FIXED_TU_PTR   = 10'h000;
	localparam logic [7:0]  LABEL_EQUIPPED = 8'h01;
	localparam logic [7:0]  LABEL_UNEQUIP  = 8'h00;
	localparam logic [3:0]  RDI_PERSIST_SHORT = 4'h5;
	localparam logic [3:0]  RDI_PERSIST_LONG  = 4'hA;
	localparam logic [2:0]  LABEL_PERSIST     = 3'h5;
	localparam logic [22:0] PAT15_TAPS = 23'h006000;
	localparam logic [22:0] LONG_PATTERN_SELECT_TAPS = 23'h420000;
endpackage : mapper_ctrl_pkg

/* File: logic/mapper_tx_test_control_regs.sv */
// Functional notes
// - fast tracking follows pointer every frame
// - overhead gen in external timing, pointer 6000H
// - H4 carries 8-bit frame count
// - long select picks 2^23-1 else 2^15-1
// - analyzer counts errors in 16-bit counter
// - analyzer source tx or rx data
// - tx generator replaces decoder output
// - rx generator replaces coder input
// - b3 override sends processor byte
// - otherwise byte masks computed B3 bits
// - fixed pointer sends zero, ignores J1
// - else compensate movement opposite direction
// - loop invert flips phase detector output
// - transmit reset held while bit set
// - receive reset held while bit set
// - counter clear zeroes counters, self clears
// - compare expected label against received C2
// - RDI persistence 5 or 10 samples
// - FEBE counts blocks or error bits
// - label error after 5 mismatches, clear 5
`timescale 1ns/1ps
`default_nettype none
module mapper_tx_test_control_regs
	import mapper_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// frame events and path data
	input  wire logic        frame_pulse,
	input  wire logic        ptr_move_valid,
	input  wire logic        ptr_move_inc,
	input  wire logic        external_timing,
	input  wire logic [7:0]  computed_b3,
	input  wire logic [7:0]  rx_c2_byte,
	input  wire logic        rx_g1_valid,
	input  wire logic [3:0]  rx_g1_febe,
	input  wire logic        rx_g1_rdi,
	// line data
	input  wire logic        tx_decoder_bit,
	input  wire logic        rx_coder_bit,
	input  wire logic        phase_detect_raw,
	// controls towards the datapath
	output logic             tx_line_bit,
	output logic             rx_line_bit,
	output logic [7:0]       tx_b3_byte,
	output logic [7:0]       tx_h4_byte,
	output logic [9:0]       tx_tu_pointer,
	output logic             toh_enable,
	output logic [15:0]      toh_pointer,
	output logic             phase_detect_out,
	output logic             phase_detector_gain,
	output logic             transmit_section_reset,
	output logic             receive_section_reset,
	output logic             path_rdi,
	output logic             signal_label_error
);
	// =====================================================================
	// register storage
	logic [7:0]  ovh_prbs_reg, b3_ctl_reg, exp_label_reg, rdi_febe_reg, b3_byte_reg;
	logic [15:0] prbs_err_reg, febe_cnt_reg;
	logic [22:0] gen_reg, ana_reg;
	logic [7:0]  h4_cnt_reg;
	logic        ptr_phase_reg;
	logic [3:0]  rdi_cnt_reg;
	logic [2:0]  lbl_cnt_reg;
	logic [1:0]  dec_sync_reg, cod_sync_reg, pd_sync_reg;
	logic        wr_en, rd_en, hit;
	logic [9:0]  idx;
	logic [7:0]  rd_byte;
	logic [22:0] taps;
	logic        gen_fb, ana_in, ana_exp;
	logic        lbl_bad;
	logic        cnt_clear;

	assign idx     = paddr[11:2];
	assign wr_en   = psel & penable & pwrite & pready;
	assign rd_en   = psel & penable & ~pwrite & pready;
	assign cnt_clear = b3_ctl_reg[BIT_CNT_CLR];

	// =====================================================================
	// apb access: one wait state, answered in the second access cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			pready <= 1'b0;
		else
			pready <= psel & penable & ~pready;
	end

	always_comb begin
		hit = 1'b1;
		rd_byte = 8'h00;
		if (idx == {2'b00, IDX_OVH_PRBS})
			rd_byte = ovh_prbs_reg;
		else if (idx == {2'b00, IDX_B3_PTR_RST})
			rd_byte = b3_ctl_reg;
		else if (idx == {2'b00, IDX_EXP_LABEL})
			rd_byte = exp_label_reg;
		else if (idx == {2'b00, IDX_RDI_FEBE})
			rd_byte = rdi_febe_reg;
		else if (idx == {2'b00, IDX_B3_BYTE})
			rd_byte = b3_byte_reg;
		else if (idx == {2'b00, IDX_RX_C2})
			rd_byte = rx_c2_byte;
		else if (idx == {2'b00, IDX_FEBE_LO})
			rd_byte = febe_cnt_reg[7:0];
		else if (idx == {2'b00, IDX_FEBE_HI})
			rd_byte = febe_cnt_reg[15:8];
		else if (idx == {2'b00, IDX_PRBS_LO})
			rd_byte = prbs_err_reg[7:0];
		else if (idx == {2'b00, IDX_PRBS_HI})
			rd_byte = prbs_err_reg[15:8];
		else if (idx == {2'b00, IDX_STATUS})
			rd_byte = {5'h00, path_rdi, signal_label_error, 1'b0};
		else
			hit = 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (psel & penable & ~pwrite & ~pready) ? {24'h000000, rd_byte} : 32'h0000_0000;
			pslverr <= psel & penable & ~pready & ~hit;
		end
	end

	// control writes; reserved bit 5 is kept as written
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ovh_prbs_reg  <= RST_OVH_PRBS;
			b3_ctl_reg    <= RST_B3_PTR_RST;
			exp_label_reg <= RST_BYTE;
			rdi_febe_reg  <= RST_BYTE;
			b3_byte_reg   <= RST_BYTE;
		end else begin
			if (b3_ctl_reg[BIT_CNT_CLR])
				b3_ctl_reg[BIT_CNT_CLR] <= 1'b0;
			if (wr_en) begin
				if (idx == {2'b00, IDX_OVH_PRBS})
					ovh_prbs_reg <= pwdata[7:0];
				else if (idx == {2'b00, IDX_B3_PTR_RST})
					b3_ctl_reg <= pwdata[7:0];
				else if (idx == {2'b00, IDX_EXP_LABEL})
					exp_label_reg <= pwdata[7:0];
				else if (idx == {2'b00, IDX_RDI_FEBE})
					rdi_febe_reg <= {6'h00, pwdata[1:0]};
				else if (idx == {2'b00, IDX_B3_BYTE})
					b3_byte_reg <= pwdata[7:0];
			end
		end
	end

	// =====================================================================
	// line input synchronisers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dec_sync_reg <= 2'b00;
			cod_sync_reg <= 2'b00;
			pd_sync_reg  <= 2'b00;
		end else begin
			dec_sync_reg <= {dec_sync_reg[0], tx_decoder_bit};
			cod_sync_reg <= {cod_sync_reg[0], rx_coder_bit};
			pd_sync_reg  <= {pd_sync_reg[0], phase_detect_raw};
		end
	end

	// =====================================================================
	// pattern generator and analyzer, shared length select
	assign taps   = ovh_prbs_reg[BIT_LONG_PAT] ? LONG_PATTERN_SELECT_TAPS : PAT15_TAPS;
	assign gen_fb = ^(gen_reg & taps);
	assign ana_in = ovh_prbs_reg[BIT_ANA_SRC] ? dec_sync_reg[1] : cod_sync_reg[1];
	assign ana_exp = ^(ana_reg & taps);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			gen_reg <= 23'h7FFFFF;
			ana_reg <= 23'h7FFFFF;
		end else begin
			gen_reg <= {gen_reg[21:0], gen_fb};
			// self-synchronising: analyzer shifts in what it receives
			if (ovh_prbs_reg[BIT_ANA_EN])
				ana_reg <= {ana_reg[21:0], ana_in};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			prbs_err_reg <= 16'h0000;
		else if (cnt_clear)
			prbs_err_reg <= 16'h0000;
		else if (ovh_prbs_reg[BIT_ANA_EN] && (ana_in != ana_exp) && (prbs_err_reg != 16'hFFFF))
			prbs_err_reg <= prbs_err_reg + 16'h0001;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_line_bit <= 1'b0;
			rx_line_bit <= 1'b0;
		end else begin
			tx_line_bit <= ovh_prbs_reg[BIT_TX_PAT] ? gen_reg[0] : dec_sync_reg[1];
			rx_line_bit <= ovh_prbs_reg[BIT_RX_PAT] ? gen_reg[0] : cod_sync_reg[1];
		end
	end

	// =====================================================================
	// path overhead: B3, H4, transport overhead, loop control
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_b3_byte          <= 8'h00;
			toh_enable          <= 1'b0;
			toh_pointer         <= 16'h0000;
			phase_detect_out    <= 1'b0;
			phase_detector_gain <= 1'b0;
		end else begin
			tx_b3_byte <= b3_ctl_reg[BIT_B3_OVR] ? b3_byte_reg : (computed_b3 ^ b3_byte_reg);
			toh_enable <= ovh_prbs_reg[BIT_TOH_GEN] & external_timing;
			toh_pointer <= TOH_POINTER;
			phase_detect_out <= pd_sync_reg[1] ^ b3_ctl_reg[BIT_LOOP_INV];
			phase_detector_gain <= b3_ctl_reg[BIT_PD_GAIN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			h4_cnt_reg <= 8'h00;
			tx_h4_byte <= 8'h00;
		end else begin
			if (b3_ctl_reg[BIT_TX_RST])
				h4_cnt_reg <= 8'h00;
			else if (frame_pulse)
				h4_cnt_reg <= h4_cnt_reg + 8'h01;
			tx_h4_byte <= b3_ctl_reg[BIT_TX_RST] ? 8'h00 :
				(ovh_prbs_reg[BIT_H4_CNT] ? h4_cnt_reg : 8'h00);
		end
	end

	// =====================================================================
	// tug-3 pointer generation
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_tu_pointer <= FIXED_TU_PTR;
			ptr_phase_reg <= 1'b0;
		end else if (b3_ctl_reg[BIT_TX_RST] || b3_ctl_reg[BIT_FIX_PTR]) begin
			tx_tu_pointer <= FIXED_TU_PTR;
			ptr_phase_reg <= 1'b0;
		end else if (frame_pulse && ptr_move_valid) begin
			ptr_phase_reg <= ~ptr_phase_reg;
			// slow tracking answers on alternate frames only
			if (ovh_prbs_reg[BIT_FAST_PTR] || ptr_phase_reg)
				tx_tu_pointer <= ptr_move_inc ? tx_tu_pointer - 10'h001 : tx_tu_pointer + 10'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			transmit_section_reset <= 1'b0;
			receive_section_reset  <= 1'b0;
		end else begin
			transmit_section_reset <= b3_ctl_reg[BIT_TX_RST];
			receive_section_reset  <= b3_ctl_reg[BIT_RX_RST];
		end
	end

	// =====================================================================
	// receive path: RDI persistence, FEBE counting, label error
	always_ff @(posedge ref_clk) begin
		if (!reset_n || b3_ctl_reg[BIT_RX_RST]) begin
			rdi_cnt_reg <= 4'h0;
			path_rdi    <= 1'b0;
		end else if (rx_g1_valid) begin
			if (rx_g1_rdi == path_rdi)
				rdi_cnt_reg <= 4'h0;
			else if (rdi_cnt_reg + 4'h1 >= (rdi_febe_reg[BIT_RDI_PERS] ? RDI_PERSIST_SHORT : RDI_PERSIST_LONG)) begin
				path_rdi    <= rx_g1_rdi;
				rdi_cnt_reg <= 4'h0;
			end else
				rdi_cnt_reg <= rdi_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n || cnt_clear)
			febe_cnt_reg <= 16'h0000;
		else if (rx_g1_valid && rx_g1_febe != 4'h0 && rx_g1_febe <= 4'h8) begin
			if (rdi_febe_reg[BIT_FEBE_BLK])
				febe_cnt_reg <= febe_cnt_reg + 16'h0001;
			else
				febe_cnt_reg <= febe_cnt_reg + {12'h000, rx_g1_febe};
		end
	end

	assign lbl_bad = ((rx_c2_byte != exp_label_reg) && (rx_c2_byte != LABEL_EQUIPPED))
		|| (rx_c2_byte == LABEL_UNEQUIP);

	always_ff @(posedge ref_clk) begin
		if (!reset_n || b3_ctl_reg[BIT_RX_RST]) begin
			lbl_cnt_reg        <= 3'h0;
			signal_label_error <= 1'b0;
		end else if (frame_pulse) begin
			if (lbl_bad == signal_label_error)
				lbl_cnt_reg <= 3'h0;
			else if (lbl_cnt_reg + 3'h1 >= LABEL_PERSIST) begin
				signal_label_error <= lbl_bad;
				lbl_cnt_reg        <= 3'h0;
			end else
				lbl_cnt_reg <= lbl_cnt_reg + 3'h1;
		end
	end

	// =====================================================================
	// checks
	a_clear_self_ends: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cnt_clear |=> (!cnt_clear || $past(wr_en)) and (prbs_err_reg == 16'h0000))
		else $error("counter clear did not zero and self clear");
	a_b3_override: assert property (@(posedge ref_clk) disable iff (!reset_n)
		b3_ctl_reg[BIT_B3_OVR] |=> tx_b3_byte == $past(b3_byte_reg))
		else $error("b3 override byte not sent");
	a_b3_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!b3_ctl_reg[BIT_B3_OVR] |=> tx_b3_byte == ($past(computed_b3) ^ $past(b3_byte_reg)))
		else $error("b3 mask not applied");
	a_fixed_pointer: assert property (@(posedge ref_clk) disable iff (!reset_n)
		b3_ctl_reg[BIT_FIX_PTR] |=> tx_tu_pointer == FIXED_TU_PTR)
		else $error("fixed pointer not zero");
	a_toh_gen: assert property (@(posedge ref_clk) disable iff (!reset_n)
		##1 toh_enable == $past(ovh_prbs_reg[BIT_TOH_GEN] & external_timing))
		else $error("overhead enable wrong");
	a_loop_invert: assert property (@(posedge ref_clk) disable iff (!reset_n)
		##1 phase_detect_out == ($past(pd_sync_reg[1]) ^ $past(b3_ctl_reg[BIT_LOOP_INV])))
		else $error("phase detector polarity wrong");
	a_tx_reset_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
		b3_ctl_reg[BIT_TX_RST] [*2] |-> transmit_section_reset)
		else $error("transmit reset not held");
	a_rx_reset_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
		b3_ctl_reg[BIT_RX_RST] [*2] |-> receive_section_reset && !signal_label_error)
		else $error("receive reset not held");
	a_tx_pattern: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ovh_prbs_reg[BIT_TX_PAT] |=> tx_line_bit == $past(gen_reg[0]))
		else $error("tx pattern not substituted");
	a_rx_pattern: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ovh_prbs_reg[BIT_RX_PAT] |=> rx_line_bit == $past(gen_reg[0]))
		else $error("rx pattern not substituted");
	a_h4_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ovh_prbs_reg[BIT_H4_CNT] && !b3_ctl_reg[BIT_TX_RST]) |=> tx_h4_byte == $past(h4_cnt_reg))
		else $error("h4 count not sent");
	a_analyzer_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!ovh_prbs_reg[BIT_ANA_EN] && !cnt_clear) |=> $stable(prbs_err_reg))
		else $error("analyzer counted while disabled");
endmodule : mapper_tx_test_control_regs
`default_nettype wire

/* File: tb/tb_mapper_tx_test_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mapper_tx_test_control_regs import mapper_ctrl_pkg::*;;
	// ==========
	// stimulus and observed ports
	logic        ref_clk, reset_n, psel, penable, pwrite, frame_pulse, ptr_move_valid, ptr_move_inc;
	logic        external_timing, rx_g1_valid, rx_g1_rdi, tx_decoder_bit, rx_coder_bit, phase_detect_raw;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  computed_b3, rx_c2_byte, tx_b3_byte, tx_h4_byte;
	logic [3:0]  rx_g1_febe;
	logic [9:0]  tx_tu_pointer;
	logic [15:0] toh_pointer;
	logic        pready, pslverr, tx_line_bit, rx_line_bit, toh_enable, phase_detect_out, phase_detector_gain;
	logic        transmit_section_reset, receive_section_reset, path_rdi, signal_label_error, rand_line, rx_quiet;
	logic        qt[$], qr[$];
	int          errors, n_checks, cycles, mdl[256];

	mapper_tx_test_control_regs u_mapper_tx_test_control_regs (
		.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_pulse(frame_pulse), .ptr_move_valid(ptr_move_valid), .ptr_move_inc(ptr_move_inc),
		.external_timing(external_timing), .computed_b3(computed_b3), .rx_c2_byte(rx_c2_byte),
		.rx_g1_valid(rx_g1_valid), .rx_g1_febe(rx_g1_febe), .rx_g1_rdi(rx_g1_rdi),
		.tx_decoder_bit(tx_decoder_bit), .rx_coder_bit(rx_coder_bit), .phase_detect_raw(phase_detect_raw),
		.tx_line_bit(tx_line_bit), .rx_line_bit(rx_line_bit), .tx_b3_byte(tx_b3_byte), .tx_h4_byte(tx_h4_byte),
		.tx_tu_pointer(tx_tu_pointer), .toh_enable(toh_enable), .toh_pointer(toh_pointer),
		.phase_detect_out(phase_detect_out), .phase_detector_gain(phase_detector_gain),
		.transmit_section_reset(transmit_section_reset), .receive_section_reset(receive_section_reset),
		.path_rdi(path_rdi), .signal_label_error(signal_label_error));

	always #2.5 ref_clk = ~ref_clk;

	// line data is random only where the analyzer needs errors to count
	always @(posedge ref_clk) begin
		tx_decoder_bit <= rand_line ? 1'($urandom) : 1'b0;
		rx_coder_bit   <= (rand_line && !rx_quiet) ? 1'($urandom) : 1'b0;
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	// ==========
	// checking and bus tasks
	task automatic finish_test();
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input bit w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] d,
		output logic e);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		// wait for the slave: only the bench timeout ends a hung transfer
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'b1, idx, v, d, e);
		chk(e, 1'b0);
		mdl[idx] = (idx == IDX_B3_PTR_RST) ? (v & 8'hFE) : v;
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [31:0] d);
		logic e;
		apb(1'b0, idx, 8'h00, d, e);
		chk(e, 1'b0);
	endtask : rd

	task automatic rdm(input logic [7:0] idx);
		logic [31:0] d;
		rd(idx, d);
		chk(d, mdl[idx]);
	endtask : rdm

	task automatic rd16(input logic [7:0] lo, output int v);
		logic [31:0] a, b;
		rd(lo, a);
		rd(lo + 8'h01, b);
		v = {b[7:0], a[7:0]};
	endtask : rd16

	task automatic frame(input bit mv, input bit inc);
		frame_pulse    <= 1'b1;
		ptr_move_valid <= mv;
		ptr_move_inc   <= inc;
		@(posedge ref_clk);
		frame_pulse    <= 1'b0;
		ptr_move_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : frame

	task automatic g1(input bit rdi, input logic [3:0] febe);
		rx_g1_valid <= 1'b1;
		rx_g1_rdi   <= rdi;
		rx_g1_febe  <= febe;
		@(posedge ref_clk);
		rx_g1_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : g1

	// n samples of level lvl: the indication flips only on the last one
	task automatic persist(input bit is_rdi, input int n, input logic lvl);
		repeat (n - 1) if (is_rdi) g1(lvl, 4'h0); else frame(1'b0, 1'b0);
		chk(is_rdi ? path_rdi : signal_label_error, !lvl);
		if (is_rdi) g1(lvl, 4'h0); else frame(1'b0, 1'b0);
		chk(is_rdi ? path_rdi : signal_label_error, lvl);
	endtask : persist

	function automatic bit prbs_ok(input logic s[$], input int a, input int b);
		int v1 = 0;
		int v2 = 0;
		int ones = 0;
		for (int n = 23; n < 80; n++) begin
			v1 += int'(s[n] !== (s[n - a] ^ s[n - b]));
			v2 += int'(s[n] !== (s[n - b + a] ^ s[n - b]));
			ones += int'(s[n] === 1'b1);
		end
		return ones > 0 && (v1 == 0 || v2 == 0);
	endfunction : prbs_ok

	// ==========
	// main sequence
	initial begin
		logic [31:0] d;
		logic        e;
		logic [7:0]  lbl, msk, cb;
		int          p, h, c1, c2;
		{ref_clk, reset_n, psel, penable, pwrite, paddr, pwdata, frame_pulse, ptr_move_valid} = '0;
		{ptr_move_inc, external_timing, computed_b3, rx_g1_valid, rx_g1_febe, rx_g1_rdi} = '0;
		{tx_decoder_bit, rx_coder_bit, rand_line, rx_quiet, errors, n_checks, cycles} = '0;
		// an unequipped label at start would raise the label error before its own test
		rx_c2_byte = LABEL_EQUIPPED;
		phase_detect_raw = 1'b1;
		foreach (mdl[i]) mdl[i] = 0;
		mdl[IDX_B3_PTR_RST] = 32'h20;
		void'($urandom(32'hC48C96EE));
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		foreach (mdl[i]) if (i >= 8'hC6 && i <= 8'hC9) rdm(8'(i));
		apb(1'b0, 8'hFF, 8'h00, d, e);
		chk(e, 1'b1);
		chk(d, 32'h0000_0000);
		// control bits of the reset and pointer register, one at a time
		for (int b = 1; b < 5; b++) begin
			wr(IDX_B3_PTR_RST, 8'(8'h20 | (1 << b)));
			repeat (4) @(posedge ref_clk);
			chk({phase_detector_gain, phase_detect_out, transmit_section_reset, receive_section_reset},
				{b == 4, b != 3, b == 2, b == 1});
			rdm(IDX_B3_PTR_RST);
		end
		wr(IDX_B3_PTR_RST, 8'h20);
		msk = 8'($urandom);
		cb  = 8'($urandom);
		computed_b3 <= cb;
		wr(IDX_B3_BYTE, msk);
		rdm(IDX_B3_BYTE);
		chk(tx_b3_byte, cb ^ msk);
		wr(IDX_B3_PTR_RST, 8'hA0);
		repeat (3) @(posedge ref_clk);
		chk(tx_b3_byte, msk);
		wr(IDX_OVH_PRBS, 8'h40);
		chk(toh_enable, 1'b0);
		external_timing <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk({toh_enable, toh_pointer}, 17'h1_6000);
		wr(IDX_OVH_PRBS, 8'h20);
		h = tx_h4_byte;
		repeat (3) frame(1'b0, 1'b0);
		chk(tx_h4_byte, 8'(h + 3));
		// pointer: fixed, then compensating at fast and slow tracking
		wr(IDX_B3_PTR_RST, 8'h60);
		repeat (2) frame(1'b1, 1'b0);
		chk(tx_tu_pointer, FIXED_TU_PTR);
		wr(IDX_B3_PTR_RST, 8'h20);
		wr(IDX_OVH_PRBS, 8'h80);
		p = tx_tu_pointer;
		repeat (4) frame(1'b1, 1'b0);
		chk(tx_tu_pointer, 10'(p + 4));
		wr(IDX_OVH_PRBS, 8'h00);
		repeat (4) frame(1'b1, 1'b0);
		chk(tx_tu_pointer, 10'(p + 6));
		wr(IDX_OVH_PRBS, 8'h80);
		repeat (2) frame(1'b1, 1'b1);
		chk(tx_tu_pointer, 10'(p + 4));
		// signal label mismatch and recovery
		lbl = 8'(8'h10 + $urandom % 64);
		wr(IDX_EXP_LABEL, lbl);
		rdm(IDX_EXP_LABEL);
		rx_c2_byte <= lbl ^ 8'h80;
		persist(1'b0, 5, 1'b1);
		rd(IDX_RX_C2, d);
		chk(d, {24'h0, lbl ^ 8'h80});
		rx_c2_byte <= LABEL_EQUIPPED;
		persist(1'b0, 5, 1'b0);
		// remote defect persistence, short then long
		wr(IDX_RDI_FEBE, 8'h02);
		rdm(IDX_RDI_FEBE);
		persist(1'b1, 5, 1'b1);
		wr(IDX_RDI_FEBE, 8'h00);
		persist(1'b1, 10, 1'b0);
		// far end error count in both modes, from a cleared counter
		wr(IDX_B3_PTR_RST, 8'h21);
		rdm(IDX_B3_PTR_RST);
		wr(IDX_RDI_FEBE, 8'h01);
		g1(1'b0, 4'h3);
		g1(1'b0, 4'h3);
		wr(IDX_RDI_FEBE, 8'h00);
		g1(1'b0, 4'h3);
		g1(1'b0, 4'h5);
		rd16(IDX_FEBE_LO, c1);
		chk(c1, 10);
		// generators for both pattern lengths
		for (int pat = 0; pat < 2; pat++) begin
			wr(IDX_OVH_PRBS, 8'(8'h03 | (pat << 4)));
			repeat (4) @(posedge ref_clk);
			qt.delete();
			qr.delete();
			repeat (80) begin
				@(posedge ref_clk);
				qt.push_back(tx_line_bit);
				qr.push_back(rx_line_bit);
			end
			chk(prbs_ok(qt, pat ? 18 : 14, pat ? 23 : 15), 1'b1);
			chk(prbs_ok(qr, pat ? 18 : 14, pat ? 23 : 15), 1'b1);
		end
		// analyzer: random transmit data, quiet then random receive data, then disabled
		rand_line = 1'b1;
		rx_quiet  = 1'b1;
		wr(IDX_OVH_PRBS, 8'h0C);
		repeat (64) @(posedge ref_clk);
		rd16(IDX_PRBS_LO, c1);
		chk(c1 > 0, 1'b1);
		wr(IDX_OVH_PRBS, 8'h08);
		// a quiet source stops the count only once the analyzer register holds zeros
		repeat (32) @(posedge ref_clk);
		rd16(IDX_PRBS_LO, c1);
		repeat (64) @(posedge ref_clk);
		rd16(IDX_PRBS_LO, c2);
		chk(c2, c1);
		rx_quiet = 1'b0;
		rd16(IDX_PRBS_LO, c1);
		repeat (64) @(posedge ref_clk);
		rd16(IDX_PRBS_LO, c2);
		chk(c2 > c1, 1'b1);
		wr(IDX_OVH_PRBS, 8'h04);
		rd16(IDX_PRBS_LO, c1);
		repeat (64) @(posedge ref_clk);
		rd16(IDX_PRBS_LO, c2);
		chk(c2, c1);
		wr(IDX_B3_PTR_RST, 8'h21);
		rdm(IDX_B3_PTR_RST);
		rd16(IDX_PRBS_LO, c1);
		rd16(IDX_FEBE_LO, c2);
		chk(c1, 32'h0000_0000);
		chk(c2, 32'h0000_0000);
		finish_test();
	end
endmodule : tb_mapper_tx_test_control_regs
`default_nettype wire
